/* File: common/ddr_io_cell_pkg.sv */
// constants, register map and field layouts of the double-data-rate io_cell path
// assumes a 32-bit AXI4-Lite register bus and a 50 MHz clk_sys
package ddr_io_cell_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SIDE_BANK_MAX_MHZ = 150;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COUNT_W = 16;

    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LAUNCH = 4'h4;
    localparam logic [3:0] ADDR_CAPTURE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // field positions in the launch register
    localparam int unsigned LAUNCH_LO_POS = 0;
    localparam int unsigned LAUNCH_HI_POS = 8;
    localparam int unsigned LAUNCH_OE_POS = 16;
    // field positions in the status register
    localparam int unsigned STATUS_DQ_OE_POS = 16;
    localparam int unsigned STATUS_DQS_OE_POS = 17;

    // phase of the launch divider (one link clock = four clk_sys cycles)
    localparam logic [1:0] PH_SYS_RISE = 2'h3;
    localparam logic [1:0] PH_SYS_FALL = 2'h1;
    localparam logic [1:0] PH_WR_RISE = 2'h0;
    localparam logic [1:0] PH_WR_FALL = 2'h2;

    // strobe cell launch inputs: low half tied high, high half tied low
    localparam logic STROBE_LAUNCH_LO = 1'b1;
    localparam logic STROBE_LAUNCH_HI = 1'b0;

    // read strobe delay taps in clk_sys samples
    localparam int unsigned TAPS_72 = 1;
    localparam int unsigned TAPS_90 = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SHIFT_0 = 2'b00,
        SHIFT_72 = 2'b01,
        SHIFT_90 = 2'b10
    } shift_t;

    typedef struct packed {
        logic side_bank;
        shift_t shift;
        logic inv_oe;
        logic inv_capture;
        logic inv_launch;
        logic tristate_high;
        logic dqs_oe_delay;
        logic dq_oe_delay;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{side_bank: 1'b0, shift: SHIFT_90, inv_oe: 1'b0,
        inv_capture: 1'b0, inv_launch: 1'b0, tristate_high: 1'b0,
        dqs_oe_delay: 1'b1, dq_oe_delay: 1'b0};

    typedef struct packed {
        logic oe;
        logic [DATA_W-1:0] hi;
        logic [DATA_W-1:0] lo;
    } launch_t;

endpackage

/* File: logic/ddr_io_cell.sv */
// double-data-rate io_cell register path for a data group and its strobe
// assumes AXI4-Lite on clk_sys; pins and the read strobe come from outside and are synchronised
//
// Summary of operation
// - six registers and one latch per cell
// - negative-edge OE register adds half-cycle preamble
// - OE active low, inverted before primary register
// - primary OE register drives general tristate enable
// - delayed OE register drives strobe enables
// - per-cell select: primary or delayed enable
// - tristate enable active low, configurable high
// - OE, capture, data launch clock each invertible
// - data launch clock lags system by 90 degrees
// - rise, fall capture registers; latch open high
// - shifted read strobe inverted before capture
// - inverted strobe swaps high and low halves
// - strobe cell launches tied high/low toggle
// - undelayed strobe copy goes to logic cells
// - phase shift only on the strobe pin
// - one clock source, system and write outputs
// - system clock drives strobe, command, address
// - write clock lags 90, launches data
// - side banks: separate capture clock, 150 MHz
// - read strobe shifted 0/72/90 then inverted
`timescale 1ns/100ps

module ddr_io_cell #(
    parameter int unsigned W = ddr_io_cell_pkg::DATA_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory side
    output logic ck_out,
    output logic [W-1:0] dq_o,
    output logic [W-1:0] dq_oe,
    input wire logic [W-1:0] dq_i,
    output logic dqs_o,
    output logic dqs_oe,
    input wire logic dqs_i,
    output logic tristate_en,
    output logic dqs_undelayed
);
    import ddr_io_cell_pkg::*;

    // ---------------- register file ----------------
    ctrl_t ctrl_q;
    launch_t launch_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [3:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
    wire wr_go = (aw_hold_q || aw_take) && (w_hold_q || w_take) && !bvalid_q;
    wire wr_ctrl = wr_go && (wr_addr == ADDR_CTRL);
    wire wr_launch = wr_go && (wr_addr == ADDR_LAUNCH);
    wire wr_known = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_LAUNCH)
        || (wr_addr == ADDR_CAPTURE) || (wr_addr == ADDR_STATUS);
    wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] ctrl_word = {{(32 - $bits(ctrl_t)){1'b0}}, ctrl_q};
    wire [31:0] launch_word = {{(32 - $bits(launch_t)){1'b0}}, launch_q};
    wire [31:0] ctrl_next = (ctrl_word & ~strb_mask) | (wr_data & strb_mask);
    wire [31:0] launch_next = (launch_word & ~strb_mask) | (wr_data & strb_mask);

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            aw_hold_q <= (aw_hold_q || aw_take) && !wr_go;
            w_hold_q <= (w_hold_q || w_take) && !wr_go;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_q <= CTRL_RESET;
            launch_q <= '0;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_t'(ctrl_next[$bits(ctrl_t)-1:0]);
            end
            if (wr_launch) begin
                launch_q <= launch_t'(launch_next[$bits(launch_t)-1:0]);
            end
        end
    end

    // ---------------- launch clocks ----------------
    // one source, two outputs: system clock and write clock 90 degrees behind
    logic [1:0] phase_q;
    logic ck_q;
    wire sys_rise = (phase_q == PH_SYS_RISE);
    wire sys_fall = (phase_q == PH_SYS_FALL);
    // inverting the launch clock swaps its edges
    wire wr_rise = ctrl_q.inv_launch ? (phase_q == PH_WR_FALL) : (phase_q == PH_WR_RISE);
    wire wr_fall = ctrl_q.inv_launch ? (phase_q == PH_WR_RISE) : (phase_q == PH_WR_FALL);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_q <= 2'h0;
            ck_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            ck_q <= sys_rise ? 1'b1 : (sys_fall ? 1'b0 : ck_q);
        end
    end
    assign ck_out = ck_q;

    // ---------------- data cell output ----------------
    // two launch, two enable registers here; two capture registers and a latch below
    logic [W-1:0] dq_hi_q;
    logic [W-1:0] dq_lo_q;
    logic [W-1:0] dq_out_q;
    logic dq_oe_a_n_q;
    logic dq_oe_b_n_q;
    // enable taken active high, inverted to the cell's active-low sense
    wire oe_req_n = ~(launch_q.oe ^ ctrl_q.inv_oe);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dq_hi_q <= '0;
            dq_lo_q <= '0;
            dq_out_q <= '0;
            dq_oe_a_n_q <= 1'b1;
            dq_oe_b_n_q <= 1'b1;
        end else begin
            if (wr_rise) begin
                dq_hi_q <= launch_q.hi[W-1:0];
                dq_lo_q <= launch_q.lo[W-1:0];
                dq_out_q <= launch_q.hi[W-1:0];
                dq_oe_a_n_q <= oe_req_n;
            end else if (wr_fall) begin
                dq_out_q <= dq_lo_q;
                dq_oe_b_n_q <= dq_oe_a_n_q;
            end
        end
    end
    assign dq_o = dq_out_q;

    wire dq_pin_oe_n = ctrl_q.dq_oe_delay ? dq_oe_b_n_q : dq_oe_a_n_q;
    assign dq_oe = {W{~dq_pin_oe_n}};

    // ---------------- strobe cell output ----------------
    logic dqs_out_q;
    logic dqs_oe_a_n_q;
    logic dqs_oe_b_n_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dqs_out_q <= 1'b0;
            dqs_oe_a_n_q <= 1'b1;
            dqs_oe_b_n_q <= 1'b1;
        end else begin
            if (sys_rise) begin
                dqs_out_q <= STROBE_LAUNCH_HI;
                dqs_oe_a_n_q <= oe_req_n;
            end else if (sys_fall) begin
                dqs_out_q <= STROBE_LAUNCH_LO;
                dqs_oe_b_n_q <= dqs_oe_a_n_q;
            end
        end
    end
    assign dqs_o = dqs_out_q;

    // delayed enable holds the pin in high impedance half a cycle longer
    wire dqs_pin_oe_n = ctrl_q.dqs_oe_delay ? dqs_oe_b_n_q : dqs_oe_a_n_q;
    assign dqs_oe = ~dqs_pin_oe_n;
    // tristate enable shown low-active unless configured high
    assign tristate_en = ctrl_q.tristate_high ? ~dq_pin_oe_n : dq_pin_oe_n;

    // ---------------- capture side ----------------
    logic dqs_meta_q;
    logic dqs_sync_q;
    logic [W-1:0] dq_meta_q;
    logic [W-1:0] dq_sync_q;
    logic [TAPS_90-1:0] dqs_dly_q;
    logic cap_clk_q;
    logic [W-1:0] cap_rise_q;
    logic [W-1:0] cap_fall_q;
    logic [W-1:0] cap_latch_q;
    logic [COUNT_W-1:0] cap_count_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dqs_meta_q <= 1'b0;
            dqs_sync_q <= 1'b0;
            dq_meta_q <= '0;
            dq_sync_q <= '0;
            dqs_dly_q <= '0;
        end else begin
            dqs_meta_q <= dqs_i;
            dqs_sync_q <= dqs_meta_q;
            dq_meta_q <= dq_i;
            dq_sync_q <= dq_meta_q;
            dqs_dly_q <= {dqs_dly_q[TAPS_90-2:0], dqs_sync_q};
        end
    end

    // the tap delay exists on the strobe pin only; data lines are never shifted
    wire dqs_shifted = (ctrl_q.shift == SHIFT_72) ? dqs_dly_q[TAPS_72-1]
        : ((ctrl_q.shift == SHIFT_90) ? dqs_dly_q[TAPS_90-1] : dqs_sync_q);
    // inversion keeps the last word, which arrives with the strobe low
    wire strobe_clk = ~dqs_shifted ^ ctrl_q.inv_capture;
    // side banks capture on the system clock rather than a strobe
    wire cap_clk = ctrl_q.side_bank ? ck_q : strobe_clk;
    wire cap_rise = cap_clk && !cap_clk_q;
    wire cap_fall = !cap_clk && cap_clk_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            // idle strobe is low, so the inverted capture clock idles high: no false edge
            cap_clk_q <= 1'b1;
            cap_rise_q <= '0;
            cap_fall_q <= '0;
            cap_latch_q <= '0;
            cap_count_q <= '0;
        end else begin
            cap_clk_q <= cap_clk;
            if (cap_rise) begin
                cap_rise_q <= dq_sync_q;
                cap_count_q <= cap_count_q + 1'b1;
            end
            if (cap_fall) begin
                cap_fall_q <= dq_sync_q;
            end
            if (cap_clk) begin
                cap_latch_q <= cap_fall_q;
            end
        end
    end

    // with the strobe inverted the rising register carries the low half
    wire [W-1:0] cap_word_hi = cap_latch_q;
    wire [W-1:0] cap_word_lo = cap_rise_q;
    assign dqs_undelayed = dqs_sync_q;

    // ---------------- read channel ----------------
    wire [31:0] capture_word = {{(32 - 2 * W){1'b0}}, cap_word_hi, cap_word_lo};
    wire [31:0] status_word = {{(32 - STATUS_DQS_OE_POS - 1){1'b0}}, ~dqs_pin_oe_n,
        ~dq_pin_oe_n, cap_count_q};
    wire rd_known = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_LAUNCH)
        || (s_axi_araddr == ADDR_CAPTURE) || (s_axi_araddr == ADDR_STATUS);
    wire [31:0] rd_mux = (s_axi_araddr == ADDR_CTRL) ? ctrl_word
        : (s_axi_araddr == ADDR_LAUNCH) ? launch_word
        : (s_axi_araddr == ADDR_CAPTURE) ? capture_word
        : (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

/* File: tb/ddr_io_cell_asserts.sv */
// checker for the io_cell register path, bound to ddr_io_cell
// sees only the top module's ports, clk_sys domain with reset active high
`timescale 1ns/100ps
module ddr_io_cell_asserts #(
    parameter int unsigned W = ddr_io_cell_pkg::DATA_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic ck_out,
    input wire logic [W-1:0] dq_o,
    input wire logic [W-1:0] dq_oe,
    input wire logic dqs_o,
    input wire logic dqs_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_ck_high_two: assert property ($rose(ck_out) |=> ck_out ##1 !ck_out)
        else $error("ck_out high time wrong");
    a_ck_low_two: assert property ($fell(ck_out) |=> !ck_out ##1 ck_out)
        else $error("ck_out low time wrong");
    a_strobe_toggle: assert property ($changed(dqs_o) |-> dqs_o != ck_out)
        else $error("strobe not opposite to ck_out");
    a_dq_launch_phase: assert property ($changed(dq_o) |-> $past(ck_out) != $past(ck_out, 2))
        else $error("dq_o moved off the write clock phase");
    a_dq_oe_phase: assert property ($changed(dq_oe) |->
        $past(ck_out) != $past(ck_out, 2) && dq_oe == {W{dq_oe[0]}})
        else $error("dq_oe moved off phase or split");
    a_dqs_oe_phase: assert property ($changed(dqs_oe) |-> $changed(ck_out))
        else $error("dqs_oe moved off the system clock edges");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("no write response");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    a_ar_refused: assert property (s_axi_arready != s_axi_rvalid)
        else $error("arready not inverse of rvalid");
endmodule

bind ddr_io_cell ddr_io_cell_asserts #(.W(W)) u_ddr_io_cell_asserts (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .ck_out(ck_out), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o),
    .dqs_oe(dqs_oe)
);

/* File: tb/ddr_mem_model.sv */
// memory-side model: sends read bursts, takes written halves off the strobe
// dqs is pulled low on the board; dq shows the inverse once let go
`timescale 1ns/100ps
module ddr_mem_model (
    input wire logic [7:0] dq_o,
    input wire logic dqs_o,
    input wire logic dqs_oe,
    output logic [7:0] dq_i,
    output logic dqs_i,
    output logic [7:0] wr_hi,
    output logic [7:0] wr_lo
);
    initial begin
        dq_i = 8'h00;
        dqs_i = 1'b0;
        wr_hi = 8'h00;
        wr_lo = 8'h00;
    end
    always @(posedge dqs_o) if (dqs_oe) wr_hi <= dq_o;
    always @(negedge dqs_o) if (dqs_oe) wr_lo <= dq_o;
    // edge aligned words, strobe high for the first of each pair
    task automatic burst(input logic [31:0] w);
        #83;
        for (int i = 0; i < 4; i++) begin
            dq_i = w[31 - 8 * i -: 8];
            dqs_i = ~i[0];
            #80;
        end
        #80;
        dq_i = ~dq_i;
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for ddr_io_cell with the memory model on its pins
// drives AXI4-Lite by non-blocking assignment after clk_sys rises
`timescale 1ns/100ps
module tb;
    import ddr_io_cell_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] launch;
        logic [15:0] cap;
        logic oe;
        logic ts;
    } row_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] cap;
        logic [15:0] mask;
    } cap_t;
    row_t rows [5] = '{'{32'h82, 32'h1A53C, 16'hA53C, 1'b1, 1'b0},
        '{32'h86, 32'h10FF0, 16'h0FF0, 1'b1, 1'b1}, '{32'h8A, 32'h1817E, 16'h7E81, 1'b1, 1'b0},
        '{32'h8A, 32'h0817E, 16'h7E81, 1'b0, 1'b1}, '{32'hA2, 32'h0A53C, 16'hA53C, 1'b1, 1'b0}};
    cap_t caps [4] = '{'{32'h82, 16'h3344, 16'hFFFF}, '{32'h42, 16'h3344, 16'hFFFF},
        '{32'h92, 16'h2233, 16'hFFFF}, '{32'h02, 16'h3344, 16'hFFFF}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, und_q = 1'b0;
    logic [31:0] wdata = 32'h0, rd, c0;
    logic [1:0] rs, seen, ck_at;
    wire awready, wready, bvalid, arready, rvalid, ck_out, dqs_o, dqs_oe, ts_en, dqs_und, dqs_i;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] dq_o, dq_oe, dq_i, wr_hi, wr_lo;
    int error_cnt = 0, samples_checked = 0, cyc = 0, und_cnt = 0, u0;
    ddr_io_cell u_ddr_io_cell (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ck_out(ck_out),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_i(dqs_i),
        .tristate_en(ts_en), .dqs_undelayed(dqs_und));
    ddr_mem_model u_ddr_mem_model (.dq_o(dq_o), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dq_i(dq_i),
        .dqs_i(dqs_i), .wr_hi(wr_hi), .wr_lo(wr_lo));
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a run still going at cycle 20000 ends as a timeout mismatch
    always @(posedge clk_sys) begin
        cyc++;
        und_q <= dqs_und;
        if (dqs_und === 1'b1 && und_q === 1'b0) und_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        rs = bresp;
    endtask
    task automatic axi_read(input logic [3:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rd = rdata;
        rs = rresp;
    endtask
    task automatic check_reset();
        chk(32'(ts_en), 32'h1);
        chk(32'(dq_oe), 32'h0);
        chk(32'(dqs_oe), 32'h0);
        axi_read(ADDR_CTRL);
        chk(rd, 32'(CTRL_RESET));
        axi_read(4'h6);
        chk(32'(rs), 32'(RESP_SLVERR));
        $display("reset test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        check_reset();
        for (int i = 0; i < 5; i++) begin
            axi_write(ADDR_CTRL, rows[i].ctrl);
            chk(32'(rs), 32'(RESP_OKAY));
            axi_write(ADDR_LAUNCH, rows[i].launch);
            repeat (12) @(posedge clk_sys);
            chk({16'h0, wr_hi, wr_lo}, {16'h0, rows[i].cap});
            chk(32'(dq_oe), 32'({8{rows[i].oe}}));
            chk(32'(dqs_oe), 32'(rows[i].oe));
            chk(32'(ts_en), 32'(rows[i].ts));
            axi_read(ADDR_STATUS);
            chk(32'({rd[STATUS_DQS_OE_POS], rd[STATUS_DQ_OE_POS]}), 32'({2{rows[i].oe}}));
            axi_read(ADDR_CTRL);
            chk(rd, rows[i].ctrl);
        end
        $display("launch rows done");
        for (int d = 0; d < 2; d++) begin
            axi_write(ADDR_CTRL, 32'h80 | 32'(d * 3));
            axi_write(ADDR_LAUNCH, 32'h0);
            repeat (8) @(posedge clk_sys);
            axi_write(ADDR_LAUNCH, 32'h10000);
            seen = 2'b00;
            ck_at = 2'b00;
            repeat (12) begin
                @(posedge clk_sys);
                if (dq_oe[0] === 1'b1 && !seen[0]) ck_at[0] = ck_out;
                if (dqs_oe === 1'b1 && !seen[1]) ck_at[1] = ck_out;
                seen = seen | {dqs_oe === 1'b1, dq_oe[0] === 1'b1};
            end
            chk(32'({seen, ck_at}), 32'({2'b11, {2{d == 0}}}));
        end
        $display("preamble test done");
        for (int i = 0; i < 4; i++) begin
            axi_write(ADDR_CTRL, caps[i].ctrl);
            axi_read(ADDR_STATUS);
            c0 = rd;
            u0 = und_cnt;
            u_ddr_mem_model.burst(32'h11223344);
            repeat (8) @(posedge clk_sys);
            axi_read(ADDR_CAPTURE);
            chk(32'(rd[15:0] & caps[i].mask), 32'(caps[i].cap));
            axi_read(ADDR_STATUS);
            chk(32'(rd[15:0] - c0[15:0]), 32'h2);
            chk(32'(und_cnt - u0), 32'h2);
        end
        $display("capture test done");
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        check_reset();
        tally_and_finish();
    end
endmodule
